// ### logic/pnl_pkg.sv
// Package for the front-panel LED and button controller.
// Assumes a 250 MHz system clock; all timing counts derive from it.
//
// Notes on behaviour
// - Health LED solid green when healthy, red when a fault is present.
// - Health LED flashes green while laser is off via service button.
// - Trigger LED lights on any trigger: sensor, non-zero scan or software.
// - Belt LED lit while conveyor speed is non-zero, dark when stopped.
// - Serial port 1 LED green while transmitting, red while only receiving.
// - Network LED flashes green with a host link and no error, red on error.
// - Power-up: bar LEDs 3,5,1 for about 1.5 s, add 2 and 4, then all off.
// - Bar graph flashes once per measured package, never for no-dimension.
// - All five bar LEDs twinkle fast while waiting for the confirm press.
// - Confirmed save steps LEDs 5 down to 1; restore steps 1 up to 5.
// - LED 3 yellow steady while parameters move to or from backup module.
// - On success LEDs 4 and 5 green for two seconds, then off.
// - On failure LEDs 1 and 2 red for two seconds.
// - Firmware update: LEDs 1,2,4,5 on, LED 3 blinks.
// - Service button held five seconds toggles laser; all five bar LEDs on during hold.
// - Backup button saves, restore button restores, each after two presses.
// - First press held at least one second; confirm-wait entered on release.
// - Transfer starts only on a confirm press of the same button under one second.
// - Without a started sequence nothing transfers; operator repeats both presses.
// - Service button held at power-up selects recovery mode.
// - A configuration input disables the buttons; presses are then ignored, but the power-up recovery strap is still read.

package pnl_pkg;

  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned DEBOUNCE_US   = 10;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYC      = TICK_US * (CLK_HZ / 1_000_000);
  // Durations below are in 1 ms ticks
  localparam int unsigned POWERUP_A_MS  = 1500;
  localparam int unsigned POWERUP_B_MS  = 1000;
  localparam int unsigned LONG_PRESS_MS = 1000;
  localparam int unsigned LASER_HOLD_MS = 5000;
  localparam int unsigned END_SHOW_MS   = 2000;
  localparam int unsigned STEP_MS       = 200;
  localparam int unsigned CONFIRM_TO_MS = 10000;
  localparam int unsigned FLASH_MS      = 100;
  localparam int unsigned TWINKLE_BIT   = 6;
  localparam int unsigned SLOW_BIT      = 8;
  localparam logic [4:0]  BAR_OFF       = 5'h00;
  localparam logic [4:0]  BAR_ALL       = 5'h1f;
  localparam logic [4:0]  BAR_PWR_A     = 5'h15;
  localparam logic [4:0]  BAR_FW        = 5'h1b;
  localparam logic [4:0]  BAR_MID       = 5'h04;
  localparam logic [4:0]  BAR_OK        = 5'h18;
  localparam logic [4:0]  BAR_FAIL      = 5'h03;

  typedef enum logic [7:0] {
    PNL_PWR_A   = 8'h01,
    PNL_PWR_B   = 8'h02,
    PNL_IDLE    = 8'h04,
    PNL_HELD    = 8'h08,
    PNL_CONFIRM = 8'h10,
    PNL_STEP    = 8'h20,
    PNL_XFER    = 8'h40,
    PNL_END     = 8'h80
  } pnl_state_t;

endpackage : pnl_pkg

// ### logic/pnl_debounce.sv
// Two-stage synchroniser plus stability filter for one button pin.
// Assumes a raw asynchronous level; output is a clean level on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module pnl_debounce #(
  parameter int unsigned CYCLES = pnl_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Pin and clean level
  input  wire logic pin,
  output logic      level
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        lvl;
    logic [15:0] cnt;
  } pnl_db_t;

  pnl_db_t q, d;

  always_comb begin
    d    = q;
    d.s1 = pin;
    d.s2 = q.s1;
    if (q.s2 == q.lvl) begin
      d.cnt = '0;
    end else if (q.cnt == 16'(CYCLES - 1)) begin
      d.lvl = q.s2;
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;

endmodule : pnl_debounce

`default_nettype wire

// ### logic/pnl_panel.sv
// Front-panel LED and button controller top.
// Assumes status sources are on sys_clk; button pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module pnl_panel #(
  parameter int unsigned TICK_CYC = pnl_pkg::TICK_CYC,
  parameter int unsigned DB_CYC   = pnl_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Button pins, active high when pressed
  input  wire logic       btn_backup,
  input  wire logic       btn_restore,
  input  wire logic       btn_service,
  input  wire logic       buttons_enable,
  // Status sources
  input  wire logic       unit_fault,
  input  wire logic       trig_sensor,
  input  wire logic       trig_scan,
  input  wire logic       trig_soft,
  input  wire logic       belt_motion_indicator,
  input  wire logic       ser1_tx,
  input  wire logic       ser1_rx,
  input  wire logic       host_link_up,
  input  wire logic       net_error,
  input  wire logic       pkg_done,
  input  wire logic       no_dimension_result,
  input  wire logic       pkg_good,
  input  wire logic       fw_update,
  // Backup module handshake
  output logic            xfer_start,
  output logic            xfer_is_save,
  input  wire logic       xfer_done,
  input  wire logic       xfer_ok,
  // Laser and mode
  output logic            laser_on,
  output logic            recovery_mode,
  // Indicators
  output logic            led_health_g,
  output logic            led_health_r,
  output logic            led_trigger,
  output logic            led_belt,
  output logic            led_read_g,
  output logic            led_read_r,
  output logic            led_ser_g,
  output logic            led_ser_r,
  output logic            led_net_g,
  output logic            led_net_r,
  output logic [4:0]      bar_green,
  output logic [4:0]      bar_red
);

  // ----------------------------------------
  // Button conditioning
  // ----------------------------------------
  logic [2:0] pins;
  logic [2:0] lvl;
  assign pins = {btn_service, btn_restore, btn_backup};

  for (genvar i = 0; i < 3; i++) begin : g_db
    pnl_debounce #(
      .CYCLES (DB_CYC)
    ) u_db (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin     (pins[i]),
      .level   (lvl[i])
    );
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pnl_pkg::pnl_state_t st;
    logic [31:0]         div;
    logic [15:0]         ms;
    logic [15:0]         svc_ms;
    logic [2:0]          step;
    logic                save;
    logic                ok;
    logic [1:0]          btn_prev;
    logic                svc_done;
    logic                laser;
    logic                laser_by_btn;
    logic                recov;
    logic [15:0]         flash_ms;
    logic                flash_good;
    logic [7:0]          blink;
    logic                start;
    logic                trig;
    logic                belt;
    logic [4:0]          bar_g;
    logic [4:0]          bar_r;
    logic [9:0]          leds;
  } pnl_all_t;

  pnl_all_t q, d;

  logic       tick;
  logic       en_press;
  logic [1:0] xbtn;
  logic       xbtn_rel;
  logic       xbtn_press;
  logic       slow;
  logic       fast;
  logic       health_blink;

  assign tick       = (q.div == 32'(TICK_CYC - 1));
  assign xbtn       = buttons_enable ? lvl[1:0] : 2'b00;
  assign xbtn_rel   = |(q.btn_prev & ~xbtn);
  assign xbtn_press = |(xbtn & ~q.btn_prev);
  assign en_press   = buttons_enable & lvl[2];
  assign slow       = q.blink[pnl_pkg::SLOW_BIT - 1];
  assign fast       = q.blink[pnl_pkg::TWINKLE_BIT - 3];

  // ----------------------------------------
  // Laser state shown on the health LED
  // ----------------------------------------
  // Only a laser switched off from the panel flashes; a fault still wins
  assign health_blink = q.laser_by_btn & ~q.laser & slow;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d          = q;
    d.start    = 1'b0;
    d.btn_prev = xbtn;
    d.div      = tick ? '0 : q.div + 32'h1;
    if (tick) begin
      d.ms    = q.ms + 16'h1;
      d.blink = q.blink + 8'h1;
    end

    // Laser service hold: toggle once per hold after five seconds
    if (!en_press) begin
      d.svc_ms   = '0;
      d.svc_done = 1'b0;
    end else if (tick && !q.svc_done) begin
      if (q.svc_ms == 16'(pnl_pkg::LASER_HOLD_MS - 1)) begin
        d.laser        = ~q.laser;
        d.laser_by_btn = q.laser;
        d.svc_done     = 1'b1;
      end
      d.svc_ms = q.svc_ms + 16'h1;
    end

    // Quality flash, one per package except no-dimension
    if (pkg_done && !no_dimension_result) begin
      d.flash_ms   = 16'(pnl_pkg::FLASH_MS);
      d.flash_good = pkg_good;
    end else if (tick && q.flash_ms != '0) begin
      d.flash_ms = q.flash_ms - 16'h1;
    end

    case (q.st)
      pnl_pkg::PNL_PWR_A: begin
        if (tick && q.ms == 16'(pnl_pkg::POWERUP_A_MS - 1)) begin
          d.st    = pnl_pkg::PNL_PWR_B;
          d.ms    = '0;
          // Strap read from the filtered pin; the raw pin is asynchronous
          d.recov = lvl[2];
        end
      end
      pnl_pkg::PNL_PWR_B: begin
        if (tick && q.ms == 16'(pnl_pkg::POWERUP_B_MS - 1)) begin
          d.st = pnl_pkg::PNL_IDLE;
        end
      end
      pnl_pkg::PNL_IDLE: begin
        if (xbtn_press) begin
          d.st   = pnl_pkg::PNL_HELD;
          d.save = xbtn[0];
          d.ms   = '0;
        end
      end
      pnl_pkg::PNL_HELD: begin
        if (xbtn_rel) begin
          d.st = (q.ms >= 16'(pnl_pkg::LONG_PRESS_MS)) ? pnl_pkg::PNL_CONFIRM : pnl_pkg::PNL_IDLE;
          d.ms = '0;
        end
      end
      pnl_pkg::PNL_CONFIRM: begin
        if (xbtn_press) begin
          d.ms = '0;
        end
        if (xbtn_rel) begin
          // Only the same button, released within one second, confirms
          if (q.ms < 16'(pnl_pkg::LONG_PRESS_MS) && q.btn_prev[0] == q.save) begin
            d.st   = pnl_pkg::PNL_STEP;
            d.step = '0;
            d.ms   = '0;
          end else begin
            d.st = pnl_pkg::PNL_IDLE;
          end
        end else if (xbtn == 2'b00 && q.ms == 16'(pnl_pkg::CONFIRM_TO_MS)) begin
          d.st = pnl_pkg::PNL_IDLE;
        end
      end
      pnl_pkg::PNL_STEP: begin
        if (tick && q.ms == 16'(pnl_pkg::STEP_MS - 1)) begin
          d.ms   = '0;
          d.step = q.step + 3'h1;
          if (q.step == 3'h4) begin
            d.st    = pnl_pkg::PNL_XFER;
            d.start = 1'b1;
          end
        end
      end
      pnl_pkg::PNL_XFER: begin
        if (xfer_done) begin
          d.st = pnl_pkg::PNL_END;
          d.ok = xfer_ok;
          d.ms = '0;
        end
      end
      pnl_pkg::PNL_END: begin
        if (tick && q.ms == 16'(pnl_pkg::END_SHOW_MS - 1)) begin
          d.st = pnl_pkg::PNL_IDLE;
        end
      end
      default: d.st = pnl_pkg::PNL_IDLE;
    endcase

    // Bar graph with fixed priority
    d.bar_g = pnl_pkg::BAR_OFF;
    d.bar_r = pnl_pkg::BAR_OFF;
    if (fw_update) begin
      d.bar_g = pnl_pkg::BAR_FW | (slow ? pnl_pkg::BAR_MID : pnl_pkg::BAR_OFF);
    end else if (q.st == pnl_pkg::PNL_PWR_A) begin
      d.bar_g = pnl_pkg::BAR_PWR_A;
    end else if (q.st == pnl_pkg::PNL_PWR_B) begin
      d.bar_g = pnl_pkg::BAR_ALL;
    end else if (en_press && !q.svc_done) begin
      d.bar_g = pnl_pkg::BAR_ALL;
    end else if (q.st == pnl_pkg::PNL_CONFIRM) begin
      d.bar_g = fast ? pnl_pkg::BAR_ALL : pnl_pkg::BAR_OFF;
    end else if (q.st == pnl_pkg::PNL_STEP) begin
      // Save walks 5 to 1, restore walks 1 to 5
      d.bar_g = q.save ? (5'h10 >> q.step) : (5'h01 << q.step);
    end else if (q.st == pnl_pkg::PNL_XFER) begin
      d.bar_g = pnl_pkg::BAR_MID;
      d.bar_r = pnl_pkg::BAR_MID;
    end else if (q.st == pnl_pkg::PNL_END) begin
      d.bar_g = q.ok ? pnl_pkg::BAR_OK : pnl_pkg::BAR_OFF;
      d.bar_r = q.ok ? pnl_pkg::BAR_OFF : pnl_pkg::BAR_FAIL;
    end else if (q.flash_ms != '0) begin
      d.bar_g = q.flash_good ? pnl_pkg::BAR_ALL : pnl_pkg::BAR_OFF;
      d.bar_r = q.flash_good ? pnl_pkg::BAR_OFF : pnl_pkg::BAR_ALL;
    end

    // Status indicators, registered
    d.leds[0] = !unit_fault && !health_blink;
    d.leds[1] = unit_fault;
    d.leds[2] = trig_sensor | trig_scan | trig_soft;
    d.leds[3] = belt_motion_indicator;
    d.leds[4] = ser1_tx;
    d.leds[5] = ser1_rx & ~ser1_tx;
    d.leds[6] = host_link_up & ~net_error & slow;
    d.leds[7] = net_error & slow;
    d.leds[8] = (q.flash_ms != '0) & q.flash_good;
    d.leds[9] = (q.flash_ms != '0) & ~q.flash_good;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q       <= '0;
      q.st    <= pnl_pkg::PNL_PWR_A;
      q.laser <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign xfer_start    = q.start;
  assign xfer_is_save  = q.save;
  assign laser_on      = q.laser;
  assign recovery_mode = q.recov;
  assign led_health_g  = q.leds[0];
  assign led_health_r  = q.leds[1];
  assign led_trigger   = q.leds[2];
  assign led_belt      = q.leds[3];
  assign led_ser_g     = q.leds[4];
  assign led_ser_r     = q.leds[5];
  assign led_net_g     = q.leds[6];
  assign led_net_r     = q.leds[7];
  assign led_read_g    = q.leds[8];
  assign led_read_r    = q.leds[9];
  assign bar_green     = q.bar_g;
  assign bar_red       = q.bar_r;

endmodule : pnl_panel

`default_nettype wire

// ### verification/pnl_backup_model.sv
// Behavioural backup module facing the panel transfer handshake.
// Assumes xfer_start is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module pnl_backup_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Handshake
  input  wire logic xfer_start,
  input  wire logic xfer_is_save,
  output logic      xfer_done,
  output logic      xfer_ok,
  // Switch and speed
  input  wire logic wp_locked,
  input  wire logic slow
);
  logic [8:0] cnt_q;
  logic       busy_q;
  logic       save_q;

  always_ff @(posedge sys_clk) begin
    xfer_done <= 1'b0;
    // Result toggles when not qualified so a stale value is never trusted
    xfer_ok   <= ~xfer_ok;
    if (rst) begin
      busy_q  <= 1'b0;
      xfer_ok <= 1'b0;
    end else if (xfer_start) begin
      busy_q <= 1'b1;
      save_q <= xfer_is_save;
      cnt_q  <= slow ? 9'h12c : 9'h003;
    end else if (busy_q) begin
      if (cnt_q == 9'h000) begin
        busy_q    <= 1'b0;
        xfer_done <= 1'b1;
        xfer_ok   <= !(save_q && wp_locked);
      end else begin
        cnt_q <= cnt_q - 9'h001;
      end
    end
  end
endmodule : pnl_backup_model

`default_nettype wire

// ### verification/pnl_panel_monitor.sv
// Checker for the panel controller, bound to its top ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module pnl_panel_monitor (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       belt_motion_indicator,
  input wire logic       led_belt,
  input wire logic       trig_sensor,
  input wire logic       trig_scan,
  input wire logic       trig_soft,
  input wire logic       led_trigger,
  input wire logic       ser1_tx,
  input wire logic       ser1_rx,
  input wire logic       led_ser_g,
  input wire logic       led_ser_r,
  input wire logic       unit_fault,
  input wire logic       led_health_r,
  input wire logic       fw_update,
  input wire logic [4:0] bar_green,
  input wire logic [4:0] bar_red,
  input wire logic       xfer_start,
  input wire logic       xfer_done,
  input wire logic       xfer_ok,
  input wire logic       laser_on
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_xfer;
    bar_green == 5'h04 && bar_red == 5'h04 && !fw_update;
  endsequence

  a_belt_follow: assert property (!$past(rst) |-> led_belt == $past(belt_motion_indicator))
    else $error("belt led mismatch");
  a_trig_any: assert property (!$past(rst) |-> led_trigger ==
    ($past(trig_sensor) || $past(trig_scan) || $past(trig_soft))) else $error("trigger led mismatch");
  a_ser_color: assert property (!$past(rst) |-> led_ser_g == $past(ser1_tx) &&
    led_ser_r == ($past(ser1_rx) && !$past(ser1_tx))) else $error("serial led mismatch");
  a_fault_red: assert property (!$past(rst) |-> led_health_r == $past(unit_fault))
    else $error("health red mismatch");
  a_start_pulse: assert property (xfer_start |=> !xfer_start) else $error("start not a pulse");
  a_xfer_yellow: assert property (xfer_start && !fw_update |-> ##[1:3] s_xfer)
    else $error("no yellow during transfer");
  a_ok_show: assert property (s_xfer ##0 (xfer_done && xfer_ok) |-> ##[1:3]
    (bar_green == 5'h18 && bar_red == 5'h00)) else $error("no success show");
  a_fail_show: assert property (s_xfer ##0 (xfer_done && !xfer_ok) |-> ##[1:3]
    (bar_red == 5'h03 && bar_green == 5'h00)) else $error("no failure show");
  a_fw_bars: assert property (!$past(rst) && $past(fw_update) |-> (bar_green & 5'h1b) == 5'h1b)
    else $error("firmware bars wrong");
  a_laser_hold: assert property (!$past(rst) && $changed(laser_on) && !$past(fw_update) |->
    ($past(bar_green) | $past(bar_red)) == 5'h1f) else $error("laser toggled without bar");
  a_powerup_bars: assert property ($fell(rst) && !fw_update |-> ##[1:2]
    ((bar_green | bar_red) == 5'h15)) else $error("power-up bars wrong");
endmodule : pnl_panel_monitor

bind pnl_panel pnl_panel_monitor u_mon (.*);

`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the panel controller.
// Assumes TICK_CYC=4 so one tick stands for 1 ms.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic sys_clk = 0, rst = 1, en = 1, wp = 0, slow = 0;
  logic [2:0] btn = 0;
  logic belt = 0, ts = 0, tsc = 0, tso = 0, tx = 0, rx = 0, fault = 0, nerr = 0;
  logic link = 0, pd = 0, nod = 0, good = 0, fw = 0;
  wire logic xs, xsv, xd, xo, lon, rec, hg, hr, lt, lb, rg, rr, sg, sr, ng, nr;
  wire logic [4:0] bg, br;
  wire logic [4:0] bar = bg | br;
  int mismatches = 0, samples_checked = 0, cyc = 0, starts = 0;
  logic [5:0] s1, s0;

  pnl_panel #(.TICK_CYC(4), .DB_CYC(2)) dut (.sys_clk(sys_clk), .rst(rst),
    .btn_backup(btn[0]), .btn_restore(btn[1]), .btn_service(btn[2]), .buttons_enable(en),
    .unit_fault(fault), .trig_sensor(ts), .trig_scan(tsc), .trig_soft(tso),
    .belt_motion_indicator(belt), .ser1_tx(tx), .ser1_rx(rx), .host_link_up(link),
    .net_error(nerr), .pkg_done(pd), .no_dimension_result(nod), .pkg_good(good),
    .fw_update(fw), .xfer_start(xs), .xfer_is_save(xsv), .xfer_done(xd), .xfer_ok(xo),
    .laser_on(lon), .recovery_mode(rec), .led_health_g(hg), .led_health_r(hr),
    .led_trigger(lt), .led_belt(lb), .led_read_g(rg), .led_read_r(rr), .led_ser_g(sg),
    .led_ser_r(sr), .led_net_g(ng), .led_net_r(nr), .bar_green(bg), .bar_red(br));
  pnl_backup_model u_bm (.sys_clk(sys_clk), .rst(rst), .xfer_start(xs), .xfer_is_save(xsv),
    .xfer_done(xd), .xfer_ok(xo), .wp_locked(wp), .slow(slow));

  // ----
  // Helpers
  // ----
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (xs) starts++;
    if (cyc == 120000) begin
      mismatches++;
      test_done;
    end
  end
  task test_done;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task chk(input logic [19:0] s, input logic [19:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task wait_ms(input int ms);
    repeat (ms * 4) @(negedge sys_clk);
  endtask : wait_ms
  task press(input int b, input int ms);
    btn[b] = 1;
    wait_ms(ms);
    btn[b] = 0;
    wait_ms(5);
  endtask : press
  // Records which indicators were seen high and low over a window
  task watch(input int ms);
    logic [5:0] v;
    s1 = 0;
    s0 = 0;
    repeat (ms * 4) begin
      @(negedge sys_clk);
      v = {bg[2], ng, hg, &bar, |bar, &bg};
      s1 |= v;
      s0 |= ~v;
    end
  endtask : watch

  // ----
  // Scenarios
  // ----
  task t_powerup;
    wait_ms(100);
    chk(rec, 0);
    chk(bar, 5'h15);
    wait_ms(1500);
    btn[2] = 0;
    chk(rec, 1);
    chk(bar, 5'h1f);
    wait_ms(1000);
    chk(bar, 5'h00);
  endtask : t_powerup
  task t_status;
    logic [7:0] sin [3] = '{8'b1100_1111, 8'b0010_0100, 8'b0001_0000};
    logic [5:0] sex [3] = '{6'b111010, 6'b010100, 6'b010000};
    for (int i = 0; i < 3; i++) begin
      {belt, ts, tsc, tso, tx, rx, fault, nerr} = sin[i];
      repeat (2) @(negedge sys_clk);
      chk({lb, lt, sg, sr, hr, ng}, sex[i]);
    end
    tso = 0;
    link = 1;
    fw = 1;
    watch(600);
    chk({s1[5:4], s0[5:4]}, 4'hf);
    chk(bg & 5'h1b, 5'h1b);
    fw = 0;
    repeat (2) @(negedge sys_clk);
    chk(hg, 1);
  endtask : t_status
  task t_quality;
    {pd, nod, good} = 3'b110;
    @(negedge sys_clk);
    pd = 0;
    watch(50);
    chk(s1[1], 0);
    {pd, nod, good} = 3'b101;
    @(negedge sys_clk);
    pd = 0;
    watch(50);
    chk(s1[0], 1);
    chk({rg, rr}, 2'b10);
    wait_ms(100);
  endtask : t_quality
  task t_xfer(input int b, input logic lock, input logic [19:0] ord_exp);
    logic [4:0] mask;
    logic [19:0] ord;
    wp = lock;
    slow = 1;
    press(b, 1050);
    watch(200);
    chk({s1[2], s0[1]}, 2'b11);
    press(b, 300);
    mask = 0;
    ord = 0;
    for (int i = 0; i < 8000 && !xs; i++) begin
      @(negedge sys_clk);
      for (int k = 0; k < 5; k++) if (bar[k] && !mask[k]) ord = {ord[15:0], 4'(k)};
      mask |= bar;
    end
    chk({xs, xsv}, {1'b1, b == 0});
    chk(ord, ord_exp);
    repeat (3) @(negedge sys_clk);
    chk({bg, br}, 10'h084);
    for (int i = 0; i < 400 && !xd; i++) @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
    chk({bg, br}, lock ? 10'h003 : 10'h300);
    wait_ms(1950);
    chk({bg, br}, lock ? 10'h003 : 10'h300);
    wait_ms(100);
    chk(bar, 5'h00);
  endtask : t_xfer
  task t_refuse;
    int s;
    s = starts;
    press(0, 300);
    watch(200);
    chk(s1[1], 0);
    en = 0;
    press(1, 1050);
    watch(200);
    chk(s1[1], 0);
    en = 1;
    press(0, 1050);
    press(0, 1050);
    wait_ms(1200);
    chk(bar, 0);
    chk(20'(starts - s), 0);
  endtask : t_refuse
  task t_laser;
    btn[2] = 1;
    wait_ms(2500);
    chk(bar, 5'h1f);
    wait_ms(2550);
    btn[2] = 0;
    wait_ms(5);
    chk({lon, bar}, 6'h00);
    watch(600);
    chk({s1[3], s0[3]}, 2'b11);
  endtask : t_laser

  initial begin
    btn[2] = 1;
    repeat (16) @(negedge sys_clk);
    rst = 0;
    repeat (2) @(negedge sys_clk);
    t_powerup;
    t_status;
    t_quality;
    t_xfer(0, 1, 20'h43210);
    t_xfer(1, 0, 20'h01234);
    t_refuse;
    t_laser;
    test_done;
  end
endmodule : tb_top

`default_nettype wire
